//--- pkg/rpdec_pkg.sv
// Package for the reference pulse decoder: setting codes, timing counts, carrier types.
// Assumes a single 100 MHz core clock and settings latched at restart.
package rpdec_pkg;

  // ---------------------------------------------------------------
  // Setting codes
  // ---------------------------------------------------------------
  localparam logic [3:0] RPDEC_CTRL_POSITION = 4'h1;
  localparam logic [3:0] RPDEC_FORM_SIGN_POS = 4'h0;
  localparam logic [3:0] RPDEC_FORM_CWCCW_POS = 4'h1;
  localparam logic [3:0] RPDEC_FORM_QUAD_X1 = 4'h2;
  localparam logic [3:0] RPDEC_FORM_QUAD_X2 = 4'h3;
  localparam logic [3:0] RPDEC_FORM_QUAD_X4 = 4'h4;
  localparam logic [3:0] RPDEC_FORM_SIGN_NEG = 4'h5;
  localparam logic [3:0] RPDEC_FORM_CWCCW_NEG = 4'h6;
  localparam logic [3:0] RPDEC_FILT_LINE = 4'h0;
  localparam logic [3:0] RPDEC_FILT_OPEN = 4'h1;
  localparam logic [3:0] RPDEC_FILT_LINE2 = 4'h2;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int RPDEC_CLK_MHZ = 100;
  // Least stable widths per filter, in ns; each count is half the width in core cycles
  localparam int RPDEC_FILT_LINE_NS = 500;
  localparam int RPDEC_FILT_OPEN_NS = 2500;
  localparam int RPDEC_FILT_LINE2_NS = 120;
  localparam int RPDEC_FILT_LINE_CYC = RPDEC_FILT_LINE_NS * RPDEC_CLK_MHZ / 1000 / 2;
  localparam int RPDEC_FILT_OPEN_CYC = RPDEC_FILT_OPEN_NS * RPDEC_CLK_MHZ / 1000 / 2;
  localparam int RPDEC_FILT_LINE2_CYC = RPDEC_FILT_LINE2_NS * RPDEC_CLK_MHZ / 1000 / 2;
  // Position loop control period
  localparam int RPDEC_CTRL_PERIOD_NS = 62500;
  localparam int RPDEC_CTRL_PERIOD_CYC = RPDEC_CTRL_PERIOD_NS * RPDEC_CLK_MHZ / 1000;
  localparam int RPDEC_CNT_W = 16;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0] control_method_select;
    logic [3:0] pulse_form_select;
    logic [3:0] filter_select;
  } rpdec_cfg_t;

  typedef struct packed {
    logic fwd;
    logic rev;
  } rpdec_step_t;

endpackage : rpdec_pkg

//--- design/rpdec_filter.sv
// Input deglitch filter for one pulse line: two-flop synchroniser then a stability count.
// Assumes the line is asynchronous to core_clk; length is chosen at restart.
`timescale 1ns/10ps
module rpdec_filter #(
  parameter int CNT_W = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic line_in,
  input wire logic [CNT_W-1:0] stable_len,
  output logic line_out
);
  import rpdec_pkg::*;

  logic sync1_q;
  logic sync2_q;
  logic [CNT_W-1:0] cnt_q;

  initial begin
    if (CNT_W < 2) $error("rpdec_filter: CNT_W too small");
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= line_in;
      sync2_q <= sync1_q;
    end
  end

  // Output follows the line only after it has held for stable_len + 1 cycles
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_q <= '0;
      line_out <= 1'b0;
    end else if (sync2_q == line_out) begin
      cnt_q <= '0;
    end else if (cnt_q >= stable_len) begin
      cnt_q <= '0;
      line_out <= sync2_q;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

endmodule : rpdec_filter

//--- design/rpdec_decoder.sv
// Reference pulse decoder: turns a host pulse train into signed position steps.
// Assumes pin inputs are asynchronous; settings are latched one cycle after rst falls.
// Function
// - Position mode only with position control code
// - Sign positive: direction high means forward
// - Sign negative: direction low means forward
// - Two-line format; idle low or idle high
// - Quadrature multiplier 1, 2, 4 by codes
// - B leading A forward, lagging reverse
// - Host keeps pulse rate under limit
// - Quadrature rate limit before multiplication
// - Filter select by code, after restart
// - Conducting open-collector driver reads high
`timescale 1ns/10ps
module rpdec_decoder #(
  parameter int CNT_W = 16,
  parameter int CTRL_PERIOD_CYC = rpdec_pkg::RPDEC_CTRL_PERIOD_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire rpdec_pkg::rpdec_cfg_t cfg,
  input wire logic pulse_line,
  input wire logic direction_line,
  output logic position_mode,
  output logic config_error,
  output logic signed [CNT_W-1:0] position_delta,
  output logic position_delta_valid,
  output logic step_fwd,
  output logic step_rev
);
  import rpdec_pkg::*;

  localparam int FILT_W = 8;
  localparam int PER_W = $clog2(CTRL_PERIOD_CYC + 1);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  initial begin
    if (CNT_W < 4) $error("rpdec_decoder: CNT_W too small");
    if (CTRL_PERIOD_CYC < 1) $error("rpdec_decoder: CTRL_PERIOD_CYC must be positive");
    if (RPDEC_FILT_OPEN_CYC >= (1 << FILT_W)) $error("rpdec_decoder: filter count too wide");
  end

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic logic is_quad(input logic [3:0] form);
    is_quad = (form == RPDEC_FORM_QUAD_X1) || (form == RPDEC_FORM_QUAD_X2) ||
              (form == RPDEC_FORM_QUAD_X4);
  endfunction : is_quad

  function automatic logic form_valid(input logic [3:0] form);
    form_valid = (form <= RPDEC_FORM_CWCCW_NEG);
  endfunction : form_valid

  // ---------------------------------------------------------------
  // Settings captured at restart only
  // ---------------------------------------------------------------
  // Live changes are ignored so a mid-run edit cannot corrupt the count
  logic armed_q;
  rpdec_cfg_t cfg_q;
  logic [FILT_W-1:0] filt_len_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      armed_q <= 1'b0;
      cfg_q <= '0;
    end else if (!armed_q) begin
      armed_q <= 1'b1;
      cfg_q <= cfg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      filt_len_q <= FILT_W'(RPDEC_FILT_LINE_CYC);
    end else if (!armed_q) begin
      case (cfg.filter_select)
        RPDEC_FILT_OPEN: filt_len_q <= FILT_W'(RPDEC_FILT_OPEN_CYC);
        RPDEC_FILT_LINE2: filt_len_q <= FILT_W'(RPDEC_FILT_LINE2_CYC);
        default: filt_len_q <= FILT_W'(RPDEC_FILT_LINE_CYC);
      endcase
    end
  end

  logic active;
  assign active = armed_q && (cfg_q.control_method_select == RPDEC_CTRL_POSITION) &&
                  form_valid(cfg_q.pulse_form_select);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      position_mode <= 1'b0;
      config_error <= 1'b0;
    end else begin
      position_mode <= active;
      config_error <= armed_q && !form_valid(cfg_q.pulse_form_select);
    end
  end

  // ---------------------------------------------------------------
  // Filtered lines
  // ---------------------------------------------------------------
  // Pins arrive at electrical level; a conducting open-collector driver is already high
  logic a_f;
  logic b_f;

  rpdec_filter #(.CNT_W(FILT_W)) u_filt_a (
    .core_clk(core_clk),
    .rst(rst),
    .line_in(pulse_line),
    .stable_len(filt_len_q),
    .line_out(a_f)
  );

  rpdec_filter #(.CNT_W(FILT_W)) u_filt_b (
    .core_clk(core_clk),
    .rst(rst),
    .line_in(direction_line),
    .stable_len(filt_len_q),
    .line_out(b_f)
  );

  logic a_q;
  logic b_q;
  logic prim_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
      prim_q <= 1'b0;
    end else begin
      a_q <= a_f;
      b_q <= b_f;
      prim_q <= active;
    end
  end

  // ---------------------------------------------------------------
  // Step decode
  // ---------------------------------------------------------------
  // Host keeps within rate limits; a faster train is not guaranteed to count
  rpdec_step_t step;
  logic a_rise;
  logic a_fall;
  logic b_rise;
  logic b_fall;
  logic a_edge;
  logic b_edge;

  assign a_rise = a_f && !a_q;
  assign a_fall = !a_f && a_q;
  assign b_rise = b_f && !b_q;
  assign b_fall = !b_f && b_q;
  assign a_edge = a_rise || a_fall;
  assign b_edge = b_rise || b_fall;

  always_comb begin
    step = '0;
    // First cycle after arming only seeds edge history
    if (active && prim_q) begin
      case (cfg_q.pulse_form_select)
        RPDEC_FORM_SIGN_POS: begin
          step.fwd = a_rise && b_f;
          step.rev = a_rise && !b_f;
        end
        RPDEC_FORM_SIGN_NEG: begin
          step.fwd = a_fall && !b_f;
          step.rev = a_fall && b_f;
        end
        RPDEC_FORM_CWCCW_POS: begin
          step.fwd = a_rise;
          step.rev = b_rise;
        end
        RPDEC_FORM_CWCCW_NEG: begin
          step.fwd = a_fall;
          step.rev = b_fall;
        end
        RPDEC_FORM_QUAD_X1: begin
          // One count per cycle, on the A rising edge; B already high means B leads
          step.fwd = a_rise && b_f;
          step.rev = a_rise && !b_f;
        end
        RPDEC_FORM_QUAD_X2: begin
          step.fwd = a_edge && (a_f == b_f);
          step.rev = a_edge && (a_f != b_f);
        end
        RPDEC_FORM_QUAD_X4: begin
          // Simultaneous A and B edges are illegal and dropped
          if (a_edge != b_edge) begin
            step.fwd = a_edge ? (a_f == b_f) : (a_f != b_f);
            step.rev = a_edge ? (a_f != b_f) : (a_f == b_f);
          end
        end
        default: step = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      step_fwd <= 1'b0;
      step_rev <= 1'b0;
    end else begin
      step_fwd <= step.fwd;
      step_rev <= step.rev;
    end
  end

  // ---------------------------------------------------------------
  // Accumulation and hand-over
  // ---------------------------------------------------------------
  logic signed [CNT_W-1:0] acc_q;
  logic signed [CNT_W-1:0] acc_step;
  logic [PER_W-1:0] per_q;
  logic tick;

  assign tick = (per_q == PER_W'(CTRL_PERIOD_CYC - 1));
  assign acc_step = step.fwd ? CNT_W'(1) : (step.rev ? -CNT_W'(1) : '0);

  always_ff @(posedge core_clk) begin
    if (rst || !active) begin
      per_q <= '0;
    end else if (tick) begin
      per_q <= '0;
    end else begin
      per_q <= per_q + 1'b1;
    end
  end

  // A step in the hand-over cycle starts the next window, so none is lost
  always_ff @(posedge core_clk) begin
    if (rst || !active) begin
      acc_q <= '0;
    end else if (tick) begin
      acc_q <= acc_step;
    end else begin
      acc_q <= acc_q + acc_step;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      position_delta <= '0;
      position_delta_valid <= 1'b0;
    end else begin
      position_delta_valid <= active && tick;
      if (active && tick) begin
        position_delta <= acc_q;
      end
    end
  end

endmodule : rpdec_decoder

//--- verification/rpdec_chk.sv
// Checker for the reference pulse decoder ports.
// Assumes cfg is held steady from reset until the next reset.
`timescale 1ns/10ps
module rpdec_chk #(
  parameter int CNT_W = 16,
  parameter int CTRL_PERIOD_CYC = rpdec_pkg::RPDEC_CTRL_PERIOD_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire rpdec_pkg::rpdec_cfg_t cfg,
  input wire logic pulse_line,
  input wire logic direction_line,
  input wire logic position_mode,
  input wire logic config_error,
  input wire logic signed [CNT_W-1:0] position_delta,
  input wire logic position_delta_valid,
  input wire logic step_fwd,
  input wire logic step_rev
);
  import rpdec_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ---------------------------------------------------------------
  // Window spacing counter
  // ---------------------------------------------------------------
  logic [15:0] gap_q;
  logic seen_q;
  always_ff @(posedge core_clk) begin
    if (rst || position_delta_valid) begin
      gap_q <= 16'h0000;
    end else begin
      gap_q <= gap_q + 16'h0001;
    end
  end
  always_ff @(posedge core_clk) begin
    seen_q <= rst ? 1'b0 : (seen_q || position_delta_valid);
  end
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  mode_code_a: assert property ($rose(position_mode) |->
    cfg.control_method_select == RPDEC_CTRL_POSITION) else $error("mode without code");
  mode_error_a: assert property (config_error |-> !position_mode)
    else $error("mode with bad form");
  step_mode_a: assert property ((step_fwd || step_rev) |-> position_mode)
    else $error("step outside position mode");
  step_excl_a: assert property (!(step_fwd && step_rev))
    else $error("both step pulses");
  step_pulse_a: assert property ((step_fwd || step_rev) |=> !(step_fwd || step_rev))
    else $error("step pulse too long");
  window_gap_a: assert property (position_delta_valid && seen_q |->
    gap_q == 16'(CTRL_PERIOD_CYC - 1)) else $error("window period wrong");
  delta_hold_a: assert property ($changed(position_delta) |-> position_delta_valid)
    else $error("delta moved off window");
  sign_pos_a: assert property (step_fwd && cfg.pulse_form_select == RPDEC_FORM_SIGN_POS
    |-> direction_line) else $error("forward with sign low");
  sign_neg_a: assert property (step_fwd && cfg.pulse_form_select == RPDEC_FORM_SIGN_NEG
    |-> !direction_line) else $error("forward with sign high");
  cover property (step_fwd);
  cover property (step_rev);
  cover property (position_delta_valid && position_delta != '0);
endmodule : rpdec_chk

bind rpdec_decoder rpdec_chk #(.CNT_W(CNT_W), .CTRL_PERIOD_CYC(CTRL_PERIOD_CYC)) u_rpdec_chk (
  .core_clk(core_clk), .rst(rst), .cfg(cfg), .pulse_line(pulse_line),
  .direction_line(direction_line), .position_mode(position_mode),
  .config_error(config_error), .position_delta(position_delta),
  .position_delta_valid(position_delta_valid), .step_fwd(step_fwd), .step_rev(step_rev));

//--- verification/rpdec_host.sv
// Host controller model driving the reference pulse pins.
// Assumes the bench calls idle before reset and send afterwards.
`timescale 1ns/10ps
module rpdec_host (
  input wire logic core_clk,
  output logic pulse_line,
  output logic direction_line
);
  import rpdec_pkg::*;
  logic [3:0] form;
  // ---------------------------------------------------------------
  // Pin drive; levels are as seen, a conducting driver reads high
  // ---------------------------------------------------------------
  task automatic idle(input logic [3:0] f);
    form = f;
    pulse_line = (f == RPDEC_FORM_SIGN_NEG) || (f == RPDEC_FORM_CWCCW_NEG);
    direction_line = (f == RPDEC_FORM_CWCCW_NEG);
  endtask : idle
  task automatic hold(input int h); // h keeps the rate legal
    repeat (h) @(negedge core_clk);
  endtask : hold
  task automatic send(input int n, input logic fwd, input int h);
    logic inv;
    logic cw;
    inv = (form == RPDEC_FORM_SIGN_NEG) || (form == RPDEC_FORM_CWCCW_NEG);
    cw = (form == RPDEC_FORM_CWCCW_POS) || (form == RPDEC_FORM_CWCCW_NEG);
    for (int i = 0; i < n; i++) begin
      if (form >= RPDEC_FORM_QUAD_X1 && form <= RPDEC_FORM_QUAD_X4) begin
        for (int k = 0; k < 4; k++) begin
          hold(h);
          if ((k % 2 == 0) == fwd) begin // B leads A when forward
            direction_line = !direction_line;
          end else begin
            pulse_line = !pulse_line;
          end
        end
      end else begin
        if (!cw) begin
          direction_line = fwd ^ inv;
        end
        for (int k = 0; k < 2; k++) begin
          hold(h);
          if (cw && !fwd) begin // reverse steps on their own line
            direction_line = !direction_line;
          end else begin
            pulse_line = !pulse_line;
          end
        end
      end
    end
  endtask : send
endmodule : rpdec_host

//--- verification/tb_top.sv
// Self-checking bench for the reference pulse decoder.
// Assumes the host model and bound checker are compiled alongside.
`timescale 1ns/10ps
module tb_top;
  import rpdec_pkg::*;
  localparam logic [3:0] POS = RPDEC_CTRL_POSITION;
  logic core_clk = 1'b0;
  logic rst;
  rpdec_cfg_t cfg;
  logic pulse_line, direction_line, position_mode, config_error;
  logic position_delta_valid, step_fwd, step_rev;
  logic signed [15:0] position_delta;
  int miscompares = 0;
  int compares = 0;
  int nf, nr, sum;
  always #5 core_clk = ~core_clk;
  rpdec_decoder #(.CNT_W(16), .CTRL_PERIOD_CYC(16)) u_rpdec_decoder (
    .core_clk(core_clk), .rst(rst), .cfg(cfg), .pulse_line(pulse_line),
    .direction_line(direction_line), .position_mode(position_mode),
    .config_error(config_error), .position_delta(position_delta),
    .position_delta_valid(position_delta_valid), .step_fwd(step_fwd), .step_rev(step_rev));
  rpdec_host u_rpdec_host (.core_clk(core_clk), .pulse_line(pulse_line),
    .direction_line(direction_line));
  // ---------------------------------------------------------------
  // Tallies, cleared by reset so each test starts from zero
  // ---------------------------------------------------------------
  always @(negedge core_clk) begin
    if (rst) begin
      nf = 0;
      nr = 0;
      sum = 0;
    end else begin
      nf += (step_fwd === 1'b1);
      nr += (step_rev === 1'b1);
      if (position_delta_valid === 1'b1) sum += position_delta;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic run(input logic [3:0] c, input logic [3:0] f, input logic [3:0] l,
                     input int h, input int m, input logic md);
    @(negedge core_clk);
    rst = 1'b1;
    cfg = '{c, f, l};
    u_rpdec_host.idle(f);
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    repeat (40) @(negedge core_clk);
    u_rpdec_host.send(3, 1'b1, h);
    u_rpdec_host.send(2, 1'b0, h);
    repeat (200) @(negedge core_clk);
    check(nf, 3 * m);
    check(nr, 2 * m);
    check(sum, m);
    check(position_mode, md);
    check(config_error, f > 4'h6);
    $display("test cfg %0h %0h %0h done", c, f, l);
  endtask : run
  task automatic end_sim();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim
  initial begin
    rst = 1'b1;
    cfg = '0;
    u_rpdec_host.idle(4'h0);
    run(POS, RPDEC_FORM_SIGN_POS, RPDEC_FILT_LINE, 40, 1, 1'b1);
    run(POS, RPDEC_FORM_SIGN_NEG, RPDEC_FILT_LINE, 40, 1, 1'b1);
    run(POS, RPDEC_FORM_CWCCW_POS, RPDEC_FILT_LINE, 40, 1, 1'b1);
    run(POS, RPDEC_FORM_CWCCW_NEG, RPDEC_FILT_LINE, 40, 1, 1'b1);
    run(POS, RPDEC_FORM_QUAD_X1, RPDEC_FILT_LINE, 40, 1, 1'b1);
    run(POS, RPDEC_FORM_QUAD_X2, RPDEC_FILT_LINE, 40, 2, 1'b1);
    run(POS, RPDEC_FORM_QUAD_X4, RPDEC_FILT_LINE, 40, 4, 1'b1);
    run(4'h0, RPDEC_FORM_SIGN_POS, RPDEC_FILT_LINE, 40, 0, 1'b0);
    run(POS, 4'h7, RPDEC_FILT_LINE, 40, 0, 1'b0);
    // Short pulses: only the fast filter may pass them
    run(POS, RPDEC_FORM_SIGN_POS, RPDEC_FILT_LINE, 13, 0, 1'b1);
    run(POS, RPDEC_FORM_SIGN_POS, RPDEC_FILT_LINE2, 13, 1, 1'b1);
    run(POS, RPDEC_FORM_SIGN_POS, RPDEC_FILT_OPEN, 40, 0, 1'b1);
    // Open-collector train at its 200 kpps ceiling
    run(POS, RPDEC_FORM_SIGN_POS, RPDEC_FILT_OPEN, 250, 1, 1'b1);
    end_sim();
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    miscompares++;
    end_sim();
  end
endmodule : tb_top
